// ===== verilog/slpc_top.sv
// module: stall prevention, current and torque limiting with apb registers
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module slpc_top #(
	parameter int TICK_CYC = slpc_pkg::TICK_CYC
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] output_current,
	input  wire logic [15:0] torque_current,
	input  wire logic [15:0] output_freq,
	input  wire logic        accel_phase,
	input  wire logic        decel_phase,
	input  wire logic        regen_phase,
	input  wire logic        regen_avoid_active,
	input  wire logic        overvoltage_stall_state,
	input  wire logic        second_function_select,
	output logic             freq_lower,
	output logic             freq_raise,
	output logic             output_shutoff,
	output logic             overload_terminal,
	output logic             stall_fault_trip
);

	// ************************************************************
	// registers
	// ************************************************************
	logic [15:0] base_r;
	logic [15:0] second_r;
	logic [15:0] comp_r;
	logic [15:0] redf_r;
	logic [6:0]  opsel_r;
	logic        lq_r;
	logic [7:0]  term_r;
	logic [15:0] delay_r;
	logic [15:0] fast_lim_r;
	logic [15:0] maxf_r;
	logic        ol_flag_r;
	logic        ol_nxt;
	logic        fault_nxt;
	logic        fault_clr;
	logic [15:0] act_lvl;
	logic        sec_r;

	logic acc_en;
	logic wr_en;
	assign acc_en    = psel && penable && !pready;
	assign wr_en     = psel && penable && pready && pwrite;
	assign fault_clr = wr_en && paddr == slpc_pkg::OFS_STATUS && pwdata[slpc_pkg::ST_FAULT_BIT];

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= slpc_pkg::OFS_STATUS;
	endfunction

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			base_r     <= slpc_pkg::BASE_RST;
			second_r   <= slpc_pkg::KEEP;
			comp_r     <= slpc_pkg::KEEP;
			redf_r     <= slpc_pkg::REDF_RST;
			opsel_r    <= slpc_pkg::OPSEL_RST;
			lq_r       <= 1'b0;
			term_r     <= slpc_pkg::TERM_POS;
			delay_r    <= slpc_pkg::DELAY_RST;
			fast_lim_r <= slpc_pkg::FAST_RST;
			maxf_r     <= slpc_pkg::MAXF_RST;
		end else if (wr_en) begin
			unique case (paddr)
				slpc_pkg::OFS_BASE: begin
					base_r <= pwdata[15:0];
				end
				slpc_pkg::OFS_SECOND: begin
					second_r <= pwdata[15:0];
				end
				slpc_pkg::OFS_COMP: begin
					comp_r <= pwdata[15:0];
				end
				slpc_pkg::OFS_REDF: begin
					redf_r <= pwdata[15:0];
				end
				slpc_pkg::OFS_MODE: begin
					opsel_r <= pwdata[6:0];
					lq_r    <= pwdata[slpc_pkg::MODE_LQ_BIT];
					term_r  <= pwdata[slpc_pkg::MODE_TERM_LSB +: 8];
				end
				slpc_pkg::OFS_DELAY: begin
					delay_r <= pwdata[15:0];
				end
				slpc_pkg::OFS_LIMITS: begin
					fast_lim_r <= pwdata[15:0];
					maxf_r     <= pwdata[31:16];
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// apb answer: one wait state, data and error from flip-flops
	// ************************************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= acc_en;
			pslverr <= acc_en && !mapped(paddr);
			if (acc_en && !pwrite) begin
				unique case (paddr)
					slpc_pkg::OFS_BASE:   prdata <= {16'h0000, base_r};
					slpc_pkg::OFS_SECOND: prdata <= {16'h0000, second_r};
					slpc_pkg::OFS_COMP:   prdata <= {16'h0000, comp_r};
					slpc_pkg::OFS_REDF:   prdata <= {16'h0000, redf_r};
					slpc_pkg::OFS_MODE:   prdata <= {8'h00, term_r, 7'h00, lq_r, 1'b0, opsel_r};
					slpc_pkg::OFS_DELAY:  prdata <= {16'h0000, delay_r};
					slpc_pkg::OFS_LIMITS: prdata <= {maxf_r, fast_lim_r};
					slpc_pkg::OFS_STATUS: prdata <= {act_lvl, 11'h000, sec_r, output_shutoff,
						stall_fault_trip, ol_flag_r, freq_lower | freq_raise};
					default:              prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ************************************************************
	// second function select pin synchroniser
	// ************************************************************
	logic sec_s1;
	logic sec_s2;
	logic sec_s3;

	// first stage feeds the second stage only; a change counts once stages two and three agree
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sec_s1 <= 1'b0;
			sec_s2 <= 1'b0;
			sec_s3 <= 1'b0;
			sec_r  <= 1'b0;
		end else begin
			sec_s1 <= second_function_select;
			sec_s2 <= sec_s1;
			sec_s3 <= sec_s2;
			if (sec_s2 == sec_s3) begin
				sec_r <= sec_s3;
			end
		end
	end

	// ************************************************************
	// level selection and comparison
	// ************************************************************
	logic              tick;
	logic [15:0]       sel_lvl;
	logic [15:0]       meas;
	logic              phase_en;
	logic              torque_mute;
	logic              stall_act;
	logic              fast_hit;
	logic              tq_regen;
	slpc_pkg::slpc_op_t op;

	slpc_tick #(
		.CYC (TICK_CYC)
	) u_tick (
		.clock  (clock),
		.resetn (resetn),
		.tick_r (tick)
	);

	// second level 9999 falls back to base, 0 disables like base 0
	assign sel_lvl = (sec_r && second_r != slpc_pkg::KEEP) ? second_r : base_r;

	slpc_level u_level (
		.clock    (clock),
		.resetn   (resetn),
		.base_lvl (sel_lvl),
		.comp     (comp_r),
		.start_f  (redf_r),
		.fout     (output_freq),
		.level_r  (act_lvl)
	);

	assign op          = slpc_pkg::opsel_decode(opsel_r, regen_phase);
	assign meas        = lq_r ? torque_current : output_current;
	assign phase_en    = accel_phase ? op.acc : (decel_phase ? op.dec : op.cst);
	assign torque_mute = lq_r && decel_phase && output_freq <= slpc_pkg::F_5HZ;
	assign stall_act   = sel_lvl != 16'h0000 && act_lvl != 16'h0000 && phase_en && !torque_mute
		&& meas > act_lvl && !stall_fault_trip;
	assign fast_hit    = op.fast && output_current > fast_lim_r;
	assign tq_regen    = lq_r && regen_phase;

	// ************************************************************
	// frequency steering and shutoff
	// ************************************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			freq_lower     <= 1'b0;
			freq_raise     <= 1'b0;
			output_shutoff <= 1'b0;
		end else begin
			freq_lower     <= stall_act && !tq_regen && (accel_phase || !decel_phase);
			freq_raise     <= stall_act && (tq_regen ? output_freq < maxf_r : decel_phase && !accel_phase);
			output_shutoff <= fast_hit || fault_nxt;
		end
	end

	// ************************************************************
	// overload flag, its delay and hold
	// ************************************************************
	logic        ol_cause;
	logic        ol_due;
	logic        ol_supp;
	logic [15:0] dly_ms_r;
	logic [15:0] hold_ms_r;

	assign ol_cause = stall_act || regen_avoid_active || overvoltage_stall_state;
	assign ol_supp  = delay_r == slpc_pkg::KEEP;
	assign ol_due   = ol_cause && (delay_r == 16'h0000
		|| 32'(dly_ms_r) >= 32'(delay_r) * 32'(slpc_pkg::DLY_UNIT_MS));

	always_comb begin
		if (ol_flag_r) begin
			ol_nxt = !(!ol_cause && hold_ms_r > 16'(slpc_pkg::OL_HOLD_MS));
		end else begin
			ol_nxt = ol_due && !op.trip;
		end
		ol_nxt = ol_nxt && !ol_supp;
	end

	// delay restarts whenever the cause drops before it expires
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dly_ms_r <= 16'h0000;
		end else if (!ol_cause || ol_flag_r) begin
			dly_ms_r <= 16'h0000;
		end else if (tick && dly_ms_r != 16'hFFFF) begin
			dly_ms_r <= dly_ms_r + 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hold_ms_r <= 16'h0000;
		end else if (!ol_flag_r) begin
			hold_ms_r <= 16'h0000;
		end else if (tick && hold_ms_r <= 16'(slpc_pkg::OL_HOLD_MS)) begin
			hold_ms_r <= hold_ms_r + 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ol_flag_r         <= 1'b0;
			overload_terminal <= 1'b0;
		end else begin
			ol_flag_r         <= ol_nxt;
			overload_terminal <= ol_nxt ^ (term_r == slpc_pkg::TERM_NEG);
		end
	end

	// ************************************************************
	// stall fault trip
	// ************************************************************
	logic        low_stall;
	logic        trip_set;
	logic [15:0] low_ms_r;

	assign low_stall = stall_act && output_freq <= slpc_pkg::F_1HZ;
	assign trip_set  = (low_stall && low_ms_r == 16'(slpc_pkg::FAULT_MS)) || (op.trip && ol_due);
	// set wins over a software clear in the same cycle
	assign fault_nxt = trip_set || (stall_fault_trip && !fault_clr);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			low_ms_r <= 16'h0000;
		end else if (!low_stall) begin
			low_ms_r <= 16'h0000;
		end else if (tick && low_ms_r < 16'(slpc_pkg::FAULT_MS)) begin
			low_ms_r <= low_ms_r + 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stall_fault_trip <= 1'b0;
		end else begin
			stall_fault_trip <= fault_nxt;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_low_done;
		low_stall && low_ms_r == 16'(slpc_pkg::FAULT_MS);
	endsequence

	sequence s_ol_release;
		ol_flag_r ##1 !ol_flag_r;
	endsequence

	a_fast_shutoff: assert property (fast_hit |=> output_shutoff)
		else $error("fast limit did not shut the output off");

	a_accel_lower: assert property (stall_act && accel_phase && !tq_regen |=> freq_lower && !freq_raise)
		else $error("stall while accelerating did not lower frequency");

	a_decel_raise: assert property (stall_act && decel_phase && !accel_phase && !lq_r |=> freq_raise && !freq_lower)
		else $error("stall while decelerating did not raise frequency");

	a_ol_hold_time: assert property (s_ol_release |-> $past(hold_ms_r) > 16'(slpc_pkg::OL_HOLD_MS) || $past(ol_supp))
		else $error("overload flag released before its hold time");

	a_ol_suppressed: assert property (ol_supp |=> !ol_flag_r)
		else $error("overload flag raised while suppressed");

	a_term_polarity: assert property ($stable(term_r) |-> overload_terminal == (ol_flag_r ^ (term_r == slpc_pkg::TERM_NEG)))
		else $error("terminal polarity does not follow function code");

	a_trip_after_low: assert property (s_low_done |=> stall_fault_trip && output_shutoff)
		else $error("prolonged low frequency stall did not trip");

	a_torque_mute: assert property (lq_r && decel_phase && output_freq <= slpc_pkg::F_5HZ |-> !stall_act)
		else $error("torque limit active while decelerating at low frequency");

	a_fast_no_ol: assert property (fast_hit && !ol_cause && !ol_flag_r |=> !ol_flag_r)
		else $error("fast limit alone raised the overload flag");

	a_delay_clear: assert property (!ol_cause && !ol_flag_r |=> dly_ms_r == 16'h0000 && !ol_flag_r)
		else $error("overload delay not cleared when the stall ended");

endmodule
`default_nettype wire

// ===== verilog/slpc_pkg.sv
// package: constants, register map and helpers of the stall prevention block
// Function
// - measured current above the active stall level steers output frequency to lower current
// - fast-response limit enabled and current above limit shuts the output off
// - base stall level in 0.1 percent of rated current, default 150, zero disables
// - acting: accelerating lowers, constant speed lowers, decelerating raises frequency
// - overload flag held over 100ms, released when current is back at level
// - overload delay: 0 immediate, 0.1 to 25s delayed, 9999 never output
// - regeneration avoidance or overvoltage stall drive the overload flag likewise
// - terminal function code 3 gives active-high flag, 103 gives active-low
// - stall holding frequency at 1Hz for 3s raises the stall fault trip
// - limit quantity 0 compares output current, 1 compares torque current
// - torque limiting in regeneration raises frequency, bounded by maximum frequency
// - torque limiting inactive while decelerating at 5Hz or below
// - second level: 0 disables, 0.1 to 200 percent alternative, 9999 reuses base
// - reduction start frequency, 0 to 400Hz, default 50Hz, starts level decrease
// - above start frequency level follows A+B*((L-A)/(L-B))*((C-100)/100)
// - compensation factor 9999 keeps level fixed at base setting up to 400Hz
// - operation selection 0 to 31, 100, 101 enables functions per condition
// - second function select input switches to the second stall level
// - fast-response current limiting alone never raises the overload flag
package slpc_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_NS      = 8;
	localparam int TICK_NS     = 1000000;
	localparam int TICK_CYC    = TICK_NS / CLK_NS;
	localparam int OL_HOLD_MS  = 100;
	localparam int FAULT_S     = 3;
	localparam int FAULT_MS    = FAULT_S * 1000;
	localparam int DLY_UNIT_MS = 100;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFS_BASE   = 8'h00;
	localparam logic [7:0] OFS_SECOND = 8'h04;
	localparam logic [7:0] OFS_COMP   = 8'h08;
	localparam logic [7:0] OFS_REDF   = 8'h0C;
	localparam logic [7:0] OFS_MODE   = 8'h10;
	localparam logic [7:0] OFS_DELAY  = 8'h14;
	localparam logic [7:0] OFS_LIMITS = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;

	// ************************************************************
	// fields, values and reset values
	// ************************************************************
	localparam int MODE_LQ_BIT   = 8;
	localparam int MODE_TERM_LSB = 16;
	localparam int ST_FAULT_BIT  = 2;
	localparam logic [15:0] KEEP        = 16'h270F;
	localparam logic [15:0] BASE_RST    = 16'h05DC;
	localparam logic [15:0] REDF_RST    = 16'h01F4;
	localparam logic [15:0] FAST_RST    = 16'h07D0;
	localparam logic [15:0] MAXF_RST    = 16'h04B0;
	localparam logic [15:0] DELAY_RST   = 16'h0000;
	localparam logic [6:0]  OPSEL_RST   = 7'h00;
	localparam logic [15:0] PCT_100     = 16'h0064;
	localparam logic [15:0] F_TOP       = 16'h0FA0;
	localparam logic [15:0] F_1HZ       = 16'h000A;
	localparam logic [15:0] F_5HZ       = 16'h0032;
	localparam logic [7:0]  TERM_POS    = 8'h03;
	localparam logic [7:0]  TERM_NEG    = 8'h67;
	localparam logic [6:0]  OPSEL_DR    = 7'h64;
	localparam logic [6:0]  OPSEL_DRNF  = 7'h65;

	typedef struct packed {
		logic fast;
		logic acc;
		logic cst;
		logic dec;
		logic trip;
	} slpc_op_t;

	// selection code to enables; codes 100/101 act only while driving
	function automatic slpc_op_t opsel_decode(input logic [6:0] sel, input logic regen);
		slpc_op_t op;
		op = '0;
		if (sel <= 7'h1F) begin
			op.fast = !sel[0];
			op.acc  = !sel[1];
			op.cst  = !sel[2];
			op.dec  = !sel[3];
			op.trip = sel[4];
		end else if ((sel == OPSEL_DR || sel == OPSEL_DRNF) && !regen) begin
			op.fast = (sel == OPSEL_DR);
			op.acc  = 1'b1;
			op.cst  = 1'b1;
			op.dec  = 1'b1;
		end else if (sel > 7'h1F && sel != OPSEL_DR && sel != OPSEL_DRNF) begin
			op = 5'h1E;
		end
		return op;
	endfunction

endpackage

// ===== verilog/slpc_tick.sv
// module: millisecond enable pulse from the system clock
`timescale 1ns/100ps
`default_nettype none
module slpc_tick #(
	parameter int CYC = slpc_pkg::TICK_CYC
) (
	input  wire logic clock,
	input  wire logic resetn,
	output logic      tick_r
);
	localparam int W = $clog2(CYC);
	localparam logic [W-1:0] LAST = W'(CYC - 1);

	logic [W-1:0] cnt_r;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (cnt_r == LAST);
			cnt_r  <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/slpc_level.sv
// module: stall level reduction in the high frequency region
`timescale 1ns/100ps
`default_nettype none
module slpc_level (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [15:0] base_lvl,
	input  wire logic [15:0] comp,
	input  wire logic [15:0] start_f,
	input  wire logic [15:0] fout,
	output logic      [15:0] level_r
);
	longint a;
	longint b;
	longint num;
	longint den;
	longint lv;

	// wide divides in one cycle: area traded for a fixed one-cycle latency
	always_comb begin
		a   = 0;
		b   = 0;
		num = 0;
		den = 0;
		lv  = longint'(base_lvl);
		if (comp != slpc_pkg::KEEP && fout > start_f) begin
			a   = longint'(start_f) * longint'(base_lvl) / longint'(fout);
			b   = longint'(start_f) * longint'(base_lvl) / longint'(slpc_pkg::F_TOP);
			den = (longint'(base_lvl) - b) * longint'(slpc_pkg::PCT_100);
			num = b * (longint'(base_lvl) - a) * (longint'(comp) - longint'(slpc_pkg::PCT_100));
			if (den != 0) begin
				lv = a + num / den;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			// start at the reset base level: a zero level would block stall prevention right after reset
			level_r <= slpc_pkg::BASE_RST;
		end else if (lv < 0) begin
			level_r <= 16'h0000;
		end else if (lv > 65535) begin
			level_r <= 16'hFFFF;
		end else begin
			level_r <= lv[15:0];
		end
	end
endmodule
`default_nettype wire

// ===== sim/slpc_motor.sv
// partner model: motor and inverter output stage behind the stall block
`timescale 1ns/100ps
`default_nettype none
module slpc_motor (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        freq_lower,
	input  wire logic        freq_raise,
	input  wire logic        output_shutoff,
	input  wire logic [15:0] load_current,
	input  wire logic [15:0] load_torque,
	input  wire logic [15:0] target_freq,
	output logic      [15:0] output_current,
	output logic      [15:0] torque_current,
	output logic      [15:0] output_freq
);
	// ****************
	// output stage
	// ****************
	// a cut output carries no current, so a fast limit hit clears itself
	assign output_current = output_shutoff ? 16'h0000 : load_current;
	assign torque_current = output_shutoff ? 16'h0000 : load_torque;
	// commands step one count a cycle; lowering stops at 1Hz like a real ramp floor
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			output_freq <= 16'h0000;
		end else if (freq_lower) begin
			output_freq <= (output_freq > slpc_pkg::F_1HZ) ? output_freq - 16'h0001 : slpc_pkg::F_1HZ;
		end else if (freq_raise) begin
			output_freq <= output_freq + 16'h0001;
		end else if (!output_shutoff) begin
			output_freq <= target_freq;
		end
	end
endmodule
`default_nettype wire

// ===== sim/slpc_testbench.sv
// testbench: apb register access and stall scenarios against the motor model
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clock, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] load_current, load_torque, target_freq, output_current, torque_current, output_freq;
	logic        accel_phase, decel_phase, regen_phase, regen_avoid_active, overvoltage_stall_state;
	logic        second_function_select, freq_lower, freq_raise, output_shutoff, overload_terminal, stall_fault_trip;
	logic        sh, ol;
	int          errors, samples_checked, cycles;
	logic [31:0] rst_val [7];

	// short tick keeps the 3s fault count inside the run
	slpc_top #(.TICK_CYC(4)) dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .output_current, .torque_current, .output_freq, .accel_phase, .decel_phase,
		.regen_phase, .regen_avoid_active, .overvoltage_stall_state, .second_function_select,
		.freq_lower, .freq_raise, .output_shutoff, .overload_terminal, .stall_fault_trip);
	slpc_motor motor (.clock, .resetn, .freq_lower, .freq_raise, .output_shutoff, .load_current,
		.load_torque, .target_freq, .output_current, .torque_current, .output_freq);

	// ****************
	// tasks
	// ****************
	task stop_test;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: no pready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			$display("wrong value at %0t: run too long", $time);
			stop_test();
		end
	end

	// ****************
	// scenarios
	// ****************
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{accel_phase, decel_phase, regen_phase, regen_avoid_active, overvoltage_stall_state} = '0;
		second_function_select = 1'b0;
		load_current = 16'h0064;
		load_torque = 16'h0064;
		target_freq = 16'h03E8;
		errors = 0;
		samples_checked = 0;
		cycles = 0;
		rst_val = '{32'h05DC, 32'h270F, 32'h270F, 32'h01F4, 32'h00030000, 32'h0000, 32'h04B007D0};
		cyc(12);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk_word(rd, rst_val[i]);
		end
		apb(1'b0, 8'h20, 32'h0);
		chk_bit(err, 1'b1);
		apb(1'b1, 8'h02, 32'h5);
		chk_bit(err, 1'b1);
		// accelerating, constant speed, decelerating; release exactly at the level
		for (int i = 0; i < 3; i++) begin
			accel_phase <= (i == 0);
			decel_phase <= (i == 2);
			load_current <= 16'h0640;
			cyc(4);
			chk_bit(freq_lower, i != 2);
			chk_bit(freq_raise, i == 2);
			chk_bit(overload_terminal, 1'b1);
			load_current <= 16'h05DC;
			cyc(4);
			chk_bit(freq_lower | freq_raise, 1'b0);
			cyc(300);
			chk_bit(overload_terminal, 1'b1);
			cyc(150);
			chk_bit(overload_terminal, 1'b0);
		end
		decel_phase <= 1'b0;
		apb(1'b1, 8'h00, 32'h0);
		load_current <= 16'h0640;
		cyc(6);
		chk_bit(freq_lower | overload_terminal, 1'b0);
		load_current <= 16'h04B0;
		apb(1'b1, 8'h00, 32'h05DC);
		apb(1'b1, 8'h04, 32'h03E8);
		second_function_select <= 1'b1;
		cyc(8);
		chk_bit(freq_lower, 1'b1);
		second_function_select <= 1'b0;
		cyc(8);
		chk_bit(freq_lower, 1'b0);
		second_function_select <= 1'b1;
		apb(1'b1, 8'h04, 32'h0);
		load_current <= 16'h0640;
		cyc(8);
		chk_bit(freq_lower, 1'b0);
		second_function_select <= 1'b0;
		load_current <= 16'h0064;
		apb(1'b1, 8'h04, 32'h270F);
		cyc(450);
		// fast limit only: no stall steering enabled
		apb(1'b1, 8'h10, 32'h0003000E);
		load_current <= 16'h0834;
		{sh, ol} = '0;
		repeat (8) begin
			@(posedge clock);
			sh |= output_shutoff;
			ol |= overload_terminal;
		end
		chk_bit(sh, 1'b1);
		chk_bit(ol, 1'b0);
		load_current <= 16'h0064;
		apb(1'b1, 8'h10, 32'h00030000);
		// delayed flag: short stall gives nothing, long stall gives the flag
		apb(1'b1, 8'h14, 32'h1);
		load_current <= 16'h0640;
		cyc(200);
		chk_bit(overload_terminal, 1'b0);
		load_current <= 16'h05DC;
		cyc(500);
		chk_bit(overload_terminal, 1'b0);
		load_current <= 16'h0640;
		cyc(440);
		chk_bit(overload_terminal, 1'b1);
		apb(1'b1, 8'h14, 32'h270F);
		cyc(4);
		chk_bit(overload_terminal, 1'b0);
		load_current <= 16'h0064;
		apb(1'b1, 8'h14, 32'h0);
		cyc(450);
		// other causes of the flag, with both terminal polarities
		for (int k = 0; k < 4; k++) begin
			if (k == 2) apb(1'b1, 8'h10, 32'h00670000);
			regen_avoid_active <= !k[0];
			overvoltage_stall_state <= k[0];
			cyc(6);
			chk_bit(overload_terminal, !k[1]);
			{regen_avoid_active, overvoltage_stall_state} <= 2'b00;
			cyc(450);
			chk_bit(overload_terminal, k[1]);
		end
		apb(1'b1, 8'h10, 32'h00030000);
		// level reduction above the start frequency
		apb(1'b1, 8'h08, 32'h0064);
		cyc(6);
		apb(1'b0, 8'h1C, 32'h0);
		chk_word({16'h0000, rd[31:16]}, 32'h02EE);
		apb(1'b1, 8'h0C, 32'h03E8);
		cyc(6);
		apb(1'b0, 8'h1C, 32'h0);
		chk_word({16'h0000, rd[31:16]}, 32'h05DC);
		apb(1'b1, 8'h0C, 32'h01F4);
		apb(1'b1, 8'h08, 32'h270F);
		target_freq <= 16'h0BB8;
		cyc(6);
		apb(1'b0, 8'h1C, 32'h0);
		chk_word({16'h0000, rd[31:16]}, 32'h05DC);
		target_freq <= 16'h03E8;
		// torque limiting
		apb(1'b1, 8'h10, 32'h00030100);
		load_torque <= 16'h0640;
		accel_phase <= 1'b1;
		cyc(6);
		chk_bit(freq_lower, 1'b1);
		accel_phase <= 1'b0;
		regen_phase <= 1'b1;
		target_freq <= 16'h04B0;
		cyc(6);
		chk_bit(freq_raise, 1'b1);
		cyc(300);
		chk_bit(freq_raise, 1'b0);
		regen_phase <= 1'b0;
		load_torque <= 16'h0064;
		target_freq <= 16'h0028;
		cyc(6);
		decel_phase <= 1'b1;
		load_torque <= 16'h0640;
		cyc(6);
		chk_bit(freq_raise | freq_lower, 1'b0);
		decel_phase <= 1'b0;
		load_torque <= 16'h0064;
		target_freq <= 16'h03E8;
		apb(1'b1, 8'h10, 32'h00030000);
		cyc(450);
		// held at 1Hz for 3s trips; software clears the fault
		load_current <= 16'h0640;
		cyc(11900);
		chk_bit(stall_fault_trip, 1'b0);
		cyc(1200);
		chk_bit(stall_fault_trip & output_shutoff, 1'b1);
		load_current <= 16'h0064;
		apb(1'b0, 8'h1C, 32'h0);
		chk_bit(rd[2], 1'b1);
		apb(1'b1, 8'h1C, 32'h4);
		cyc(4);
		chk_bit(stall_fault_trip, 1'b0);
		// code 101: nothing in regeneration, stall steering while driving; code 16 trips at once
		regen_phase <= 1'b1;
		apb(1'b1, 8'h10, 32'h00030065);
		load_current <= 16'h0640;
		cyc(6);
		chk_bit(freq_lower | freq_raise, 1'b0);
		regen_phase <= 1'b0;
		cyc(6);
		chk_bit(freq_lower, 1'b1);
		apb(1'b1, 8'h10, 32'h00030010);
		cyc(4);
		chk_bit(stall_fault_trip & output_shutoff, 1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
